// File: logic/pmr_pkg.sv
// pmr_pkg: register map, diagnostic field layout and bus structs of the results/alert bank.
// assumes: shared by the bank and its bench; no clocked logic lives here.
`default_nettype none
package pmr_pkg;
	// register pointers (serial-bus register addresses)
	localparam logic [7:0] PTR_BUS_VOLTAGE = 8'h05;
	localparam logic [7:0] PTR_DIE_TEMP    = 8'h06;
	localparam logic [7:0] PTR_CURRENT     = 8'h07;
	localparam logic [7:0] PTR_POWER       = 8'h08;
	localparam logic [7:0] PTR_ENERGY      = 8'h09;
	localparam logic [7:0] PTR_CHARGE      = 8'h0a;
	localparam logic [7:0] PTR_DIAG        = 8'h0b;
	// 7-bit target address of the device (plain default)
	localparam logic [6:0] DEV_ADDR = 7'h40;
	// diagnostic register field positions
	localparam int DG_LATCH = 15;
	localparam int DG_ROUTE = 14;
	localparam int DG_AVGCMP = 13;
	localparam int DG_POL = 12;
	localparam int DG_ENERGY_OF = 11;
	localparam int DG_CHARGE_OF = 10;
	localparam int DG_MATH_OF = 9;
	localparam int DG_LIM_HI = 7;
	localparam int DG_LIM_LO = 2;
	localparam int DG_DONE = 1;
	localparam int DG_TRIM = 0;
	localparam logic [15:0] DIAG_RESET = 16'h0001;
	// limit flag indices inside the 6-bit limit group (bit 7 .. bit 2)
	localparam int LIM_TEMP = 5;
	localparam int LIM_OCUR = 4;
	localparam int LIM_UCUR = 3;
	localparam int LIM_BOV = 2;
	localparam int LIM_BUV = 1;
	localparam int LIM_PWR = 0;
	// result widths
	localparam int BUS_VOLTAGE_RESULT_W = 20;
	localparam int TEMP_W = 16;
	localparam int CUR_W = 20;
	localparam int PWR_W = 24;
	localparam int ACC_W = 40;
	localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;

	// one measurement set from the converter datapath
	typedef struct packed {
		logic [BUS_VOLTAGE_RESULT_W-1:0] bus_voltage_result;
		logic [TEMP_W-1:0] temp;
		logic [CUR_W-1:0]  cur;
		logic [PWR_W-1:0]  pwr;
	} pmr_meas_t;

	// limit thresholds from the configuration bank
	typedef struct packed {
		logic [15:0] tol;
		logic [15:0] col;
		logic [15:0] cul;
		logic [14:0] bovl;
		logic [14:0] buvl;
		logic [15:0] pwl;
	} pmr_thr_t;

	// samples per averaging code, minus one
	function automatic logic [9:0] avg_last(input logic [2:0] code);
		case (code)
			3'h0: avg_last = 10'h000;
			3'h1: avg_last = 10'h003;
			3'h2: avg_last = 10'h00f;
			3'h3: avg_last = 10'h03f;
			3'h4: avg_last = 10'h07f;
			3'h5: avg_last = 10'h0ff;
			3'h6: avg_last = 10'h1ff;
			default: avg_last = 10'h3ff;
		endcase
	endfunction
endpackage
`default_nettype wire

// File: logic/pmr_results_alert.sv
// pmr_results_alert: result registers, accumulators, diagnostic flags, alert pin, serial target.
// assumes: datapath signals share ref_clk; scl/sda come from pins and are synchronised here.
// Contract
// - bus voltage 20 bits in upper 24-bit field
// - low four bits of 24-bit bus voltage and current results zero
// - die temperature 16-bit signed, resets zero
// - current 20-bit signed in upper bits
// - power 24-bit unsigned result
// - energy accumulates unsigned 40 bits, resets zero
// - charge accumulates signed 40 bits
// - latched mode holds flags until diagnostic read
// - transparent mode flags follow fault condition
// - routing puts conversion-done onto alert
// - compare raw samples or averaged result
// - polarity selects active-low or active-high alert
// - energy overflow sticky until accumulator clear
// - charge overflow sticky until accumulator clear
// - arithmetic overflow cleared by conversion or clear
// - over-temperature flag, read clears when latched
// - over-current flag, read clears when latched
// - under-current flag, read clears when latched
// - bus over-voltage flag, read clears when latched
// - bus under-voltage flag, read clears when latched
// - over-power flag, read clears when latched
// - conversion-done flag, cleared by start or latched read
// - accumulator clear zeroes energy and charge
// - results update only after full averaging
// - lowest diagnostic bit shows trim memory health
`timescale 1ns/1ps
`default_nettype none
module pmr_results_alert
	import pmr_pkg::*;
(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          nrst,
	// serial bus pins (open drain)
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output logic               sda_oe_n,
	// alert pin (open drain, pulls low when enable is low)
	output logic               alert_oe_n,
	// converter datapath
	input  wire logic          sample_valid,
	input  wire pmr_pkg::pmr_meas_t raw_meas,
	input  wire pmr_pkg::pmr_meas_t avg_meas,
	input  wire logic [2:0]    averaging_count,
	input  wire logic          conv_start,
	input  wire logic          math_overflow,
	input  wire logic          accumulator_clear,
	input  wire logic          trim_memory_ok,
	// thresholds from the configuration bank
	input  wire pmr_pkg::pmr_thr_t thr
);
	import pmr_pkg::*;

	// one-hot serial target states
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_ADDR  = 9'h002,
		ST_ACK_A = 9'h004,
		ST_PTR   = 9'h008,
		ST_ACK_W = 9'h010,
		ST_WDATA = 9'h020,
		ST_RDATA = 9'h040,
		ST_ACK_R = 9'h080,
		ST_WAIT  = 9'h100
	} pmr_st_t;

	// whole module state
	typedef struct packed {
		logic [1:0]        scl_sy;    // scl synchroniser, [0] first stage
		logic [1:0]        sda_sy;    // sda synchroniser, [0] first stage
		logic              scl_d;     // delayed synced scl for edges
		logic              sda_d;     // delayed synced sda for start/stop
		pmr_st_t           st;
		logic [2:0]        bit_cnt;
		logic              byte_full; // eighth bit taken on last rise
		logic [7:0]        shift;
		logic              rw;        // 1 = host reads
		logic              nack;      // host refused the last byte
		logic [7:0]        ptr;
		logic [7:0]        whi;       // first data byte of a write
		logic              wphase;
		logic [ACC_W-1:0]  shadow;    // read snapshot, msb first
		logic              sda_oe_n;
		logic [BUS_VOLTAGE_RESULT_W-1:0] bus_voltage_result;
		logic [TEMP_W-1:0] temp;
		logic [CUR_W-1:0]  cur;
		logic [PWR_W-1:0]  pwr;
		logic [ACC_W-1:0]  energy;
		logic [ACC_W-1:0]  charge;
		logic              latch;
		logic              route;
		logic              avgcmp;
		logic              over_power_flag;
		logic              energy_of;
		logic              charge_of;
		logic              math_of;
		logic [5:0]        lim;
		logic              done_f;
		logic [9:0]        smp_cnt;
		logic              alert_oe_n;
	} pmr_state_t;

	pmr_state_t q;          // registered state
	pmr_state_t next_q;     // next value
	logic scl_rise;         // synced scl edges
	logic scl_fall;
	logic start_c;          // start or repeated start
	logic stop_c;
	logic avg_done;         // last sample of an averaging block
	logic cmp_evt;          // moment limits are evaluated
	pmr_meas_t cmp_val;     // values the limits look at
	logic [5:0] cond;       // live fault conditions
	logic diag_read;        // moment the diagnostic register is snapshotted for a read
	logic [ACC_W:0] e_sum;  // energy sum with carry
	logic [ACC_W-1:0] c_sum;
	logic c_ovf;
	logic active;           // combined alert request
	logic [15:0] diag_word;
	logic [ACC_W-1:0] rd_val;

	// edges of the synchronised pins; only second stages are looked at
	assign scl_rise = q.scl_sy[1] & ~q.scl_d;
	assign scl_fall = ~q.scl_sy[1] & q.scl_d;
	assign start_c = q.scl_sy[1] & q.scl_d & q.sda_d & ~q.sda_sy[1];
	assign stop_c = q.scl_sy[1] & q.scl_d & ~q.sda_d & q.sda_sy[1];

	// averaging: results move only on the final sample of a block
	assign avg_done = sample_valid & (q.smp_cnt == avg_last(averaging_count));
	// limit source: every raw sample or the completed average
	assign cmp_evt = q.avgcmp ? avg_done : sample_valid;
	assign cmp_val = q.avgcmp ? avg_meas : raw_meas;

	// thresholds carry 16x (bus, current), 256x (power) or 1x (temp) the result lsb
	always_comb begin
		cond[LIM_TEMP] = $signed(cmp_val.temp) > $signed(thr.tol);
		cond[LIM_OCUR] = $signed(cmp_val.cur[19:4]) > $signed(thr.col);
		cond[LIM_UCUR] = $signed(cmp_val.cur[19:4]) < $signed(thr.cul);
		cond[LIM_BOV] = cmp_val.bus_voltage_result[19:4] > {1'b0, thr.bovl};
		cond[LIM_BUV] = cmp_val.bus_voltage_result[19:4] < {1'b0, thr.buvl};
		cond[LIM_PWR] = cmp_val.pwr[23:8] > thr.pwl;
	end

	// accumulator sums; charge overflow is a signed overflow
	assign e_sum = {1'b0, q.energy} + {17'h00000, avg_meas.pwr};
	assign c_sum = q.charge + {{20{avg_meas.cur[19]}}, avg_meas.cur};
	assign c_ovf = (q.charge[39] == avg_meas.cur[19]) && (c_sum[39] != q.charge[39]);

	// alert request: OR of limit flags plus optional conversion-done
	assign active = (|q.lim) | (q.route & q.done_f);

	// diagnostic view
	assign diag_word = {q.latch, q.route, q.avgcmp, q.over_power_flag, q.energy_of, q.charge_of,
		q.math_of, 1'b0, q.lim, q.done_f, trim_memory_ok};

	// read mux, left justified so bytes leave msb first
	always_comb begin
		case (q.ptr)
			PTR_BUS_VOLTAGE: rd_val = {q.bus_voltage_result, LOW_NIBBLE_ZERO, 16'h0000};
			PTR_DIE_TEMP:    rd_val = {q.temp, 24'h000000};
			PTR_CURRENT:     rd_val = {q.cur, LOW_NIBBLE_ZERO, 16'h0000};
			PTR_POWER:       rd_val = {q.pwr, 16'h0000};
			PTR_ENERGY:      rd_val = q.energy;
			PTR_CHARGE:      rd_val = q.charge;
			PTR_DIAG:        rd_val = {diag_word, 24'h000000};
			default:         rd_val = 40'h0000000000;
		endcase
	end

	// diagnostic read happens when a read address is acknowledged
	assign diag_read = scl_fall & (q.st == ST_ADDR) & q.byte_full
		& (q.shift[7:1] == DEV_ADDR) & q.shift[0] & (q.ptr == PTR_DIAG);

	// next state: serial target, results, flags, alert
	always_comb begin
		next_q = q;
		next_q.scl_sy = {q.scl_sy[0], scl_i};
		next_q.sda_sy = {q.sda_sy[0], sda_i};
		next_q.scl_d = q.scl_sy[1];
		next_q.sda_d = q.sda_sy[1];
		// serial target
		if (start_c) begin
			next_q.st = ST_ADDR;
			next_q.bit_cnt = 3'h0;
			next_q.byte_full = 1'b0;
			next_q.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			next_q.st = ST_IDLE;
			next_q.sda_oe_n = 1'b1;
		end else if (scl_rise) begin
			// sample incoming bits of address, pointer and data bytes
			if (q.st == ST_ADDR || q.st == ST_PTR || q.st == ST_WDATA) begin
				next_q.shift = {q.shift[6:0], q.sda_sy[1]};
				next_q.bit_cnt = q.bit_cnt + 3'h1;
				next_q.byte_full = (q.bit_cnt == 3'h7);
			end
			if (q.st == ST_ACK_R) begin
				next_q.nack = q.sda_sy[1];
			end
		end else if (scl_fall) begin
			case (q.st)
				ST_ADDR: if (q.byte_full) begin
					next_q.byte_full = 1'b0;
					if (q.shift[7:1] == DEV_ADDR) begin
						next_q.st = ST_ACK_A;
						next_q.rw = q.shift[0];
						next_q.sda_oe_n = 1'b0;
						if (q.shift[0]) begin
							next_q.shadow = rd_val;
						end
					end else begin
						next_q.st = ST_WAIT;
					end
				end
				ST_ACK_A: begin
					next_q.st = q.rw ? ST_RDATA : ST_PTR;
					next_q.sda_oe_n = q.rw ? q.shadow[39] : 1'b1;
					next_q.bit_cnt = 3'h0;
				end
				ST_PTR: if (q.byte_full) begin
					next_q.byte_full = 1'b0;
					next_q.ptr = q.shift;
					next_q.wphase = 1'b0;
					next_q.st = ST_ACK_W;
					next_q.sda_oe_n = 1'b0;
				end
				ST_WDATA: if (q.byte_full) begin
					next_q.byte_full = 1'b0;
					next_q.wphase = ~q.wphase;
					next_q.st = ST_ACK_W;
					next_q.sda_oe_n = 1'b0;
					if (!q.wphase) begin
						next_q.whi = q.shift;
					end else if (q.ptr == PTR_DIAG) begin
						// only the mode bits take writes; flags are hardware owned
						next_q.latch = q.whi[DG_LATCH-8];
						next_q.route = q.whi[DG_ROUTE-8];
						next_q.avgcmp = q.whi[DG_AVGCMP-8];
						next_q.over_power_flag = q.whi[DG_POL-8];
					end
				end
				ST_ACK_W: begin
					next_q.st = ST_WDATA;
					next_q.sda_oe_n = 1'b1;
					next_q.bit_cnt = 3'h0;
				end
				ST_RDATA: begin
					next_q.shadow = {q.shadow[38:0], 1'b0};
					if (q.bit_cnt == 3'h7) begin
						next_q.st = ST_ACK_R;
						next_q.sda_oe_n = 1'b1;
						next_q.bit_cnt = 3'h0;
					end else begin
						next_q.sda_oe_n = q.shadow[38];
						next_q.bit_cnt = q.bit_cnt + 3'h1;
					end
				end
				ST_ACK_R: begin
					// past the register end the snapshot shifts out zeros
					next_q.st = q.nack ? ST_WAIT : ST_RDATA;
					next_q.sda_oe_n = q.nack ? 1'b1 : q.shadow[39];
				end
				ST_IDLE, ST_WAIT: next_q.sda_oe_n = 1'b1;
				default: begin
					next_q.st = ST_IDLE;
					next_q.sda_oe_n = 1'b1;
				end
			endcase
		end

		// averaging counter and result update
		if (sample_valid) begin
			next_q.smp_cnt = avg_done ? 10'h000 : q.smp_cnt + 10'h001;
		end
		if (avg_done) begin
			next_q.bus_voltage_result = avg_meas.bus_voltage_result;
			next_q.temp = avg_meas.temp;
			next_q.cur = avg_meas.cur;
			next_q.pwr = avg_meas.pwr;
			next_q.energy = e_sum[ACC_W-1:0];
			next_q.charge = c_sum;
		end

		// limit flags: latched ones hold until read, set beats clear
		if (q.latch) begin
			if (diag_read) begin
				next_q.lim = 6'h00;
			end
			if (cmp_evt) begin
				next_q.lim = next_q.lim | cond;
			end
		end else if (cmp_evt) begin
			next_q.lim = cond;
		end

		// conversion done: cleared by start or latched read, completion wins
		if (conv_start || (q.latch && diag_read)) begin
			next_q.done_f = 1'b0;
		end
		if (avg_done) begin
			next_q.done_f = 1'b1;
		end

		// overflow flags; clear requests lose to a same-cycle overflow
		if (accumulator_clear) begin
			next_q.energy = 40'h0000000000;
			next_q.charge = 40'h0000000000;
			next_q.energy_of = 1'b0;
			next_q.charge_of = 1'b0;
			next_q.math_of = 1'b0;
		end
		if (conv_start) begin
			next_q.math_of = 1'b0;
		end
		if (avg_done && e_sum[ACC_W]) begin
			next_q.energy_of = 1'b1;
		end
		if (avg_done && c_ovf) begin
			next_q.charge_of = 1'b1;
		end
		if (math_overflow) begin
			next_q.math_of = 1'b1;
		end

		// pin pulls low when the asserted level is low: polarity applied last
		next_q.alert_oe_n = q.over_power_flag ? active : ~active;
	end

	// state register, synchronous reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q <= '0;
			q.scl_sy <= 2'h3;
			q.sda_sy <= 2'h3;
			q.scl_d <= 1'b1;
			q.sda_d <= 1'b1;
			q.st <= ST_IDLE;
			q.sda_oe_n <= 1'b1;
			q.alert_oe_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign sda_oe_n = q.sda_oe_n;
	assign alert_oe_n = q.alert_oe_n;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_alert_pol: assert property (##1 alert_oe_n == ($past(q.over_power_flag) ? $past(active) : !$past(active)))
		else $error("alert pin level does not match polarity");
	a_latch_hold: assert property (q.latch && q.lim[LIM_TEMP] && !diag_read |=> q.lim[LIM_TEMP])
		else $error("latched flag dropped without a read");
	a_transp_clear: assert property (!q.latch && cmp_evt && !cond[LIM_OCUR] |=> !q.lim[LIM_OCUR])
		else $error("transparent flag did not follow condition");
	a_acc_clear: assert property (accumulator_clear |=> q.energy == 40'h0 && q.charge == 40'h0)
		else $error("accumulators not zeroed");
	a_energy_ovf: assert property (avg_done && e_sum[ACC_W] ##1 !accumulator_clear |-> q.energy_of ##1 q.energy_of)
		else $error("energy overflow not flagged");
	a_math_clear: assert property (conv_start && !math_overflow |=> !q.math_of)
		else $error("arithmetic overflow not cleared by start");
	a_done_set: assert property (avg_done |=> q.done_f)
		else $error("conversion done not set");
	a_avg_hold: assert property (sample_valid && !avg_done |=> $stable(q.bus_voltage_result) && $stable(q.pwr))
		else $error("results moved before averaging finished");
	a_route_alert: assert property (q.route && q.done_f && !q.over_power_flag |=> !alert_oe_n)
		else $error("routed conversion done missing on alert");
	a_snapshot: assert property (diag_read |=> q.shadow[39:24] == $past(diag_word))
		else $error("diagnostic snapshot wrong");

	c_latched_read: cover property (q.latch && |q.lim ##1 diag_read ##1 q.lim == 6'h00);
	c_read_ack: cover property (q.st == ST_ACK_A && q.rw);
	c_energy_of: cover property (q.energy_of);
	c_diag_write: cover property (q.st == ST_WDATA && q.wphase && q.ptr == PTR_DIAG);
endmodule // pmr_results_alert
`default_nettype wire

// File: verif/pmr_i2c_host.sv
// pmr_i2c_host: behavioural serial-bus host that reads results and writes the diagnostic register.
// assumes: the bench resolves sda with a pull-up; only this host drives scl, no clock stretching.
`timescale 1ns/1ps
`default_nettype none
module pmr_i2c_host
	import pmr_pkg::*;
(
	// pin drives
	output logic      scl_o,
	output logic      sda_oe_n,
	// resolved data line
	input  wire logic sda
);
	int gap = 0; // extra scl-low time after each byte, models a slow host

	// idle: both lines released, the clock stands still between frames
	initial begin
		scl_o = 1'b1;
		sda_oe_n = 1'b1;
	end

	// start or repeated start: sda falls while scl is high
	task automatic start();
		sda_oe_n = 1'b1;
		#40 scl_o = 1'b1;
		#40 sda_oe_n = 1'b0;
		#40 scl_o = 1'b0;
		#40;
	endtask

	// stop: sda rises while scl is high
	task automatic stop();
		sda_oe_n = 1'b0;
		#40 scl_o = 1'b1;
		#40 sda_oe_n = 1'b1;
		#40;
	endtask

	// one 160 ns bit; data only moves while scl is low, read back in the middle of the high phase, 40 ns before scl falls
	task automatic bit_io(input logic b, output logic r);
		sda_oe_n = b;
		#40 scl_o = 1'b1;
		#40 r = sda;
		#40 scl_o = 1'b0;
		#40;
	endtask

	// byte out msb first, then the target's answer (1 = ack)
	task automatic put(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = ~r;
		#(gap);
	endtask

	// byte in, then ack, or nack on the last one
	task automatic get(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(last, r);
		#(gap);
	endtask

	// pointer write with nd data bytes (msb first)
	task automatic wr(input logic [6:0] adr, input logic [7:0] ptr, input int nd,
			input logic [15:0] v, output logic ack);
		logic a;
		start();
		put({adr, 1'b0}, ack);
		put(ptr, a);
		if (nd > 0) put(v[15:8], a);
		if (nd > 1) put(v[7:0], a);
		stop();
	endtask

	// pointer set, repeated start, n bytes read msb first
	task automatic rd(input logic [7:0] ptr, input int n, output logic [39:0] d);
		logic a;
		logic [7:0] b;
		start();
		put({DEV_ADDR, 1'b0}, a);
		put(ptr, a);
		start();
		put({DEV_ADDR, 1'b1}, a);
		d = '0;
		for (int i = 0; i < n; i++) begin
			get(i == n - 1, b);
			d = {d[31:0], b};
		end
		stop();
	endtask
endmodule // pmr_i2c_host
`default_nettype wire

// File: verif/power_monitor_results_alert_tb.sv
// power_monitor_results_alert_tb: drives the datapath, reads registers over the serial bus.
// assumes: pmr_pkg and pmr_i2c_host compiled first; accumulator overflow is too slow to reach.
`timescale 1ns/1ps
`default_nettype none
module power_monitor_results_alert_tb;
	import pmr_pkg::*;
	localparam pmr_thr_t safe = '{tol: 16'h7fff, col: 16'h7fff, cul: 16'h8000,
		bovl: 15'h7fff, buvl: 15'h0000, pwl: 16'hffff};
	localparam pmr_meas_t viol = '{bus_voltage_result: 20'h00100, temp: 16'h0010, cur: 20'h00100,
		pwr: 24'h001000};
	// design inputs
	logic       ref_clk = 1'b0, nrst = 1'b0, sample_valid = 1'b0, trim_memory_ok = 1'b1;
	logic       conv_start = 1'b0, math_overflow = 1'b0, accumulator_clear = 1'b0;
	logic [2:0] averaging_count = 3'h0;
	pmr_meas_t  raw_meas = '0, avg_meas = '0;
	pmr_thr_t   thr = safe;
	// pins; released sda reads high through the pull-up
	logic       sda_oe_n, alert_oe_n, host_scl, host_sda_oe_n, ack;
	wire logic  sda = sda_oe_n & host_sda_oe_n;
	// reference model state
	logic [19:0] m_bus_voltage_result = '0, m_cur = '0;
	logic [15:0] m_temp = '0;
	logic [23:0] m_pwr = '0;
	logic [39:0] m_en = '0, m_ch = '0, d, e;
	logic [5:0]  m_lim = '0;
	logic [3:0]  m_mode = '0; // latch, route, avgcmp, polarity
	logic        m_done = 1'b0, m_math = 1'b0;
	logic [31:0] seed = 32'h2c488f56;
	int          m_cnt = 0, err_count = 0, check_count = 0, cyc = 0;

	pmr_results_alert DUT (.ref_clk(ref_clk), .nrst(nrst), .scl_i(host_scl), .sda_i(sda),
		.sda_oe_n(sda_oe_n), .alert_oe_n(alert_oe_n), .sample_valid(sample_valid),
		.raw_meas(raw_meas), .avg_meas(avg_meas), .averaging_count(averaging_count),
		.conv_start(conv_start), .math_overflow(math_overflow),
		.accumulator_clear(accumulator_clear), .trim_memory_ok(trim_memory_ok), .thr(thr));
	pmr_i2c_host host (.scl_o(host_scl), .sda_oe_n(host_sda_oe_n), .sda(sda));

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	// hang guard: the whole sequence needs about 61k cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_count++;
			summarize();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// random set; bus voltage kept non-negative as the converter guarantees
	function automatic pmr_meas_t rmeas();
		logic [31:0] a, b, c;
		a = rnd();
		b = rnd();
		c = rnd();
		return {1'b0, a[18:0], b[15:0], c[19:0], a[31:24], b[31:16]};
	endfunction

	// limit conditions: temp, over-cur, under-cur, bus over, bus under, power
	function automatic logic [5:0] lim(input pmr_meas_t m);
		return {$signed(m.temp) > $signed(thr.tol), $signed(m.cur[19:4]) > $signed(thr.col),
			$signed(m.cur[19:4]) < $signed(thr.cul), m.bus_voltage_result[19:4] > {1'b0, thr.bovl},
			m.bus_voltage_result[19:4] < {1'b0, thr.buvl}, m.pwr[23:8] > thr.pwl};
	endfunction

	// thresholds where only limit i trips on viol
	function automatic pmr_thr_t bad(input int i);
		pmr_thr_t t;
		t = safe;
		case (i)
			0: t.pwl = 16'h000f;
			1: t.buvl = 15'h0011;
			2: t.bovl = 15'h000f;
			3: t.cul = 16'h0011;
			4: t.col = 16'h000f;
			default: t.tol = 16'h000f;
		endcase
		return t;
	endfunction

	function automatic void upd(input logic [5:0] c);
		if (m_mode[3]) m_lim |= c;
		else m_lim = c;
	endfunction

	function automatic logic [15:0] diag_exp();
		return {m_mode, 2'b00, m_math, 1'b0, m_lim, m_done, trim_memory_ok};
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one sample pulse; model loads results on the last sample of a block
	task automatic sample(input pmr_meas_t r, input pmr_meas_t a);
		int n;
		n = (averaging_count < 4) ? (1 << (2 * averaging_count)) : (1 << (averaging_count + 3));
		raw_meas = r;
		avg_meas = a;
		sample_valid = 1'b1;
		if (!m_mode[1]) upd(lim(r));
		if (m_cnt == n - 1) begin
			if (m_mode[1]) upd(lim(a));
			{m_bus_voltage_result, m_temp, m_cur, m_pwr} = a;
			m_en += 40'(a.pwr);
			m_ch += {{20{a.cur[19]}}, a.cur};
			m_done = 1'b1;
			m_cnt = 0;
		end else m_cnt++;
		step(1);
		sample_valid = 1'b0;
		// let an edge pass so a following pulse never re-raises it in the same step
		step(1);
	endtask

	// control pulses {conv_start, math_overflow, accumulator_clear}; a new overflow wins
	task automatic ctl(input logic [2:0] k);
		{conv_start, math_overflow, accumulator_clear} = k;
		if (k[2] | k[0]) m_math = 1'b0;
		if (k[2]) m_done = 1'b0;
		if (k[0]) {m_en, m_ch} = '0;
		if (k[1]) m_math = 1'b1;
		step(1);
		{conv_start, math_overflow, accumulator_clear} = 3'h0;
		// one idle edge between pulses keeps each strobe to one assignment per step
		step(1);
	endtask

	// alert pin one cycle after the flags move
	task automatic alert_is();
		logic act, ex;
		step(1);
		act = |m_lim | (m_mode[2] & m_done);
		ex = m_mode[0] ? act : !act;
		chk(40'(alert_oe_n), 40'(ex), "alert pin");
	endtask

	task automatic wdiag(input logic [15:0] v);
		host.wr(DEV_ADDR, PTR_DIAG, 2, v, ack);
		m_mode = v[15:12];
	endtask

	task automatic rdchk(input logic [7:0] p);
		host.rd(p, (p == PTR_DIE_TEMP || p == PTR_DIAG) ? 2 :
			(p == PTR_ENERGY || p == PTR_CHARGE) ? 5 : 3, d);
		case (p)
			PTR_BUS_VOLTAGE: chk(d, {16'h0, m_bus_voltage_result, 4'h0}, "bus voltage");
			PTR_DIE_TEMP: chk(d, {24'h0, m_temp}, "temperature");
			PTR_CURRENT: chk(d, {16'h0, m_cur, 4'h0}, "current");
			PTR_POWER: chk(d, {16'h0, m_pwr}, "power");
			PTR_ENERGY: chk(d, m_en, "energy");
			PTR_CHARGE: chk(d, m_ch, "charge");
			PTR_DIAG: chk(d, {24'h0, diag_exp()}, "diagnostic");
			default: chk(d, 40'h0, "unmapped pointer");
		endcase
		// a latched diagnostic read clears the event flags
		if (p == PTR_DIAG && m_mode[3]) begin
			m_lim = '0;
			m_done = 1'b0;
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		step(12);
		nrst = 1'b1;
		step(4);
		chk(40'(alert_oe_n), 40'h1, "alert after reset");
		host.wr(7'h41, PTR_DIAG, 2, 16'h8000, ack);
		chk(40'(ack), 40'h0, "foreign address acked");
		host.wr(DEV_ADDR, PTR_POWER, 2, 16'hffff, ack);
		for (int p = 5; p < 13; p++) rdchk(8'(p));
		// every averaging code, conversion-done routed to the alert pin
		wdiag(16'h40ff);
		for (int c = 0; c < 8; c++) begin
			averaging_count = 3'(c);
			ctl(3'b100);
			alert_is();
			for (int i = 0; i < (c < 4 ? 1 << (2 * c) : 1 << (c + 3)); i++) begin
				sample(rmeas(), rmeas());
				if (i == (c < 4 ? 1 << (2 * c) : 1 << (c + 3)) - 2) alert_is();
			end
			alert_is();
			if (c == 1 || c == 7) for (int p = 5; p < 13; p++) rdchk(8'(p));
		end
		wdiag(16'h5000);
		alert_is();
		ctl(3'b100);
		alert_is();
		// overflow flag set, kept against a same-cycle start, cleared by a conversion, set again beside an accumulator clear
		ctl(3'b010);
		rdchk(PTR_DIAG);
		ctl(3'b110);
		rdchk(PTR_DIAG);
		ctl(3'b100);
		ctl(3'b011);
		for (int p = 9; p < 12; p++) rdchk(8'(p));
		trim_memory_ok = 1'b0;
		rdchk(PTR_DIAG);
		trim_memory_ok = 1'b1;
		// each limit, transparent then latched
		averaging_count = 3'h0;
		for (int i = 0; i < 6; i++) begin
			wdiag(16'h0000);
			thr = bad(i);
			sample(viol, viol);
			alert_is();
			thr = safe;
			sample(viol, viol);
			alert_is();
			wdiag(16'h8000);
			thr = bad(i);
			sample(viol, viol);
			thr = safe;
			sample(viol, viol);
			alert_is();
			rdchk(PTR_DIAG);
			alert_is();
		end
		// averaged comparison ignores raw excursions
		averaging_count = 3'h1;
		thr = bad(5);
		wdiag(16'h2000);
		for (int i = 0; i < 8; i++) begin
			sample(viol, i < 4 ? '0 : viol);
			alert_is();
		end
		// sample lands mid-read under a slow host: bytes come from the snapshot
		averaging_count = 3'h0;
		thr = safe;
		host.gap = 400;
		e = m_en;
		fork
			host.rd(PTR_ENERGY, 5, d);
			begin
				step(900);
				sample(rmeas(), rmeas());
			end
		join
		chk(d, e, "energy snapshot");
		host.gap = 0;
		rdchk(PTR_ENERGY);
		summarize();
	end
endmodule // power_monitor_results_alert_tb
`default_nettype wire
